// ### rtl/dial_and_handshake_sequencer.sv
// module: dial cadence, handshake select and carrier status with Avalon regs
`timescale 1ns/1ps
`default_nettype none
module dial_and_handshake_sequencer
	import dial_seq_pkg::*;
#(
	parameter int unsigned TICK_DIV = TICK_DIV_CYCLES
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_B,
	input  wire logic [5:0]  AVS_ADDRESS,
	input  wire logic        AVS_READ,
	input  wire logic        AVS_WRITE,
	input  wire logic [31:0] AVS_WRITEDATA,
	input  wire logic [3:0]  AVS_BYTEENABLE,
	output logic      [31:0] AVS_READDATA,
	output logic             AVS_WAITREQUEST,
	input  wire logic        REMOTE_USB1_IN,
	input  wire logic        REMOTE_S1_IN,
	input  wire logic        REMOTE_SB1_IN,
	input  wire logic        LINK_READY_IN,
	input  wire logic        CARRIER_LOSS_IN,
	input  wire logic        RETRAIN_IN,
	input  wire logic        HANGUP_IN,
	input  wire logic        RX_DATA_IN,
	output logic             RX_DATA_OUT,
	output logic             LINE_SEIZE_PIN_B,
	output logic             DTMF_ENABLE,
	output logic      [3:0]  DTMF_DIGIT,
	output logic      [15:0] HIGH_TONE_LEVEL,
	output logic      [15:0] LOW_TONE_LEVEL,
	output logic      [2:0]  TX_SIGNAL_SEL,
	output logic             AUTO_HANDSHAKE,
	output logic             FORCE_16WAY
);

	//==========================================================================
	// state
	typedef struct packed {
		logic [15:0]    mode_cfg;
		logic [15:0]    tone_stat;
		logic [7:0]     host_ctl;
		logic [7:0]     train_ctl;
		logic [15:0]    make_cnt;
		logic [15:0]    break_cnt;
		logic [15:0]    pause_cnt;
		logic [15:0]    hi_lev;
		logic [15:0]    lo_lev;
		dial_state_type dial_st;
		logic [15:0]    timer;
		logic [3:0]     pulses;
		logic           rts_prev;
		logic           busy;
		logic           off_hook;
		logic           seize_b;
		logic           dtmf_on;
		logic [2:0]     tx_sel;
		logic           auto_hs;
		logic           carrier;
		logic           retrain;
		logic           rx_out;
		logic [31:0]    readdata;
		logic           waitreq;
	} seq_state_type;

	seq_state_type           s;
	seq_state_type           next_s;
	logic [SYNC_WIDTH-1:0]   pins_async;
	logic [SYNC_WIDTH-1:0]   pins;
	logic                    tick;

	//==========================================================================
	// helpers
	function automatic logic [31:0] merge_bytes(
		input logic [31:0] old_val,
		input logic [31:0] new_val,
		input logic [3:0]  be
	);
		logic [31:0] r;
		r = old_val;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[i*8 +: 8] = new_val[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic is_connect_mode(input logic [15:0] cfg);
		return (cfg[MODE_MSB:MODE_LSB] == MODE_CONNECT) ||
			(cfg[MODE_MSB:MODE_LSB] == MODE_CONNECT_MAN);
	endfunction

	function automatic logic [3:0] pulse_count(input logic [3:0] digit);
		logic [3:0] n;
		n = 4'h0;
		if (digit == PULSE_ZERO_DIGIT) begin
			n = PULSES_FOR_ZERO;
		end else if (digit <= PULSE_MAX_DIGIT) begin
			n = digit;
		end
		return n;
	endfunction

	//==========================================================================
	// pins and sample-rate enable
	assign pins_async = {
		RX_DATA_IN,
		HANGUP_IN,
		RETRAIN_IN,
		CARRIER_LOSS_IN,
		LINK_READY_IN,
		REMOTE_SB1_IN,
		REMOTE_S1_IN,
		REMOTE_USB1_IN
	};

	pin_synchronizer #(
		.WIDTH (SYNC_WIDTH)
	) u_sync (
		.clk      (CORE_CLK),
		.rst_b    (RST_B),
		.async_in (pins_async),
		.sync_out (pins)
	);

	sample_tick #(
		.DIV (TICK_DIV)
	) u_tick (
		.clk   (CORE_CLK),
		.rst_b (RST_B),
		.tick  (tick)
	);

	//==========================================================================
	// next state
	always_comb begin
		logic        req;
		logic [31:0] rd;
		logic [31:0] wv;
		logic        in_dial;
		logic        pulse_mode;
		logic        timed;
		logic        rts;
		logic        rts_rise;
		logic        expire;
		logic        connect;
		logic        manual;
		logic [3:0]  npulse;
		req        = AVS_READ | AVS_WRITE;
		rd         = '0;
		wv         = '0;
		in_dial    = 1'b0;
		pulse_mode = 1'b0;
		timed      = 1'b0;
		rts        = 1'b0;
		rts_rise   = 1'b0;
		expire     = 1'b0;
		connect    = 1'b0;
		manual     = 1'b0;
		npulse     = '0;
		next_s     = s;

		// bus: answer one cycle after the request is seen
		case (AVS_ADDRESS)
			OFS_MODE_CONFIG: begin
				rd[15:0] = s.mode_cfg;
			end
			OFS_TONE_STATUS: begin
				rd[15:0] = s.tone_stat;
			end
			OFS_HOST_CONTROL: begin
				rd[7:0] = s.host_ctl;
			end
			OFS_HOST_STATUS: begin
				rd[CARRIER_BIT] = s.carrier;
				rd[RETRAIN_BIT] = s.retrain;
				rd[BUSY_BIT]    = s.busy;
			end
			OFS_MODEM_STATUS: begin
				rd[LINE_SEIZED_BIT] = s.off_hook;
			end
			OFS_TRAINING_CTL: begin
				rd[7:0]           = s.train_ctl;
				rd[USB1_SEEN_BIT] = pins[SYNC_USB1];
				rd[S1_SEEN_BIT]   = pins[SYNC_S1];
				rd[SB1_SEEN_BIT]  = pins[SYNC_SB1];
			end
			OFS_MAKE_COUNT: begin
				rd[15:0] = s.make_cnt;
			end
			OFS_BREAK_COUNT: begin
				rd[15:0] = s.break_cnt;
			end
			OFS_PAUSE_COUNT: begin
				rd[15:0] = s.pause_cnt;
			end
			OFS_HIGH_LEVEL: begin
				rd[15:0] = s.hi_lev;
			end
			OFS_LOW_LEVEL: begin
				rd[15:0] = s.lo_lev;
			end
			default: begin
				rd = '0;
			end
		endcase

		if (req && s.waitreq) begin
			next_s.waitreq = 1'b0;
			if (AVS_READ) begin
				next_s.readdata = rd;
			end
		end else if (req && !s.waitreq) begin
			next_s.waitreq = 1'b1;
			if (AVS_WRITE) begin
				// unmapped offsets and the host and modem status offsets ignore writes
				wv = merge_bytes(rd, AVS_WRITEDATA, AVS_BYTEENABLE);
				case (AVS_ADDRESS)
					OFS_MODE_CONFIG: begin
						next_s.mode_cfg = wv[15:0];
					end
					OFS_TONE_STATUS: begin
						next_s.tone_stat = wv[15:0];
					end
					OFS_HOST_CONTROL: begin
						next_s.host_ctl = wv[7:0] & HOST_CTL_MASK;
					end
					OFS_TRAINING_CTL: begin
						next_s.train_ctl = wv[7:0] & TRAIN_CTL_MASK;
					end
					OFS_MAKE_COUNT: begin
						next_s.make_cnt = wv[15:0];
					end
					OFS_BREAK_COUNT: begin
						next_s.break_cnt = wv[15:0];
					end
					OFS_PAUSE_COUNT: begin
						next_s.pause_cnt = wv[15:0];
					end
					OFS_HIGH_LEVEL: begin
						next_s.hi_lev = wv[15:0];
					end
					OFS_LOW_LEVEL: begin
						next_s.lo_lev = wv[15:0];
					end
					default: begin
						next_s.waitreq = 1'b1;
					end
				endcase
			end
		end

		// dial sequencing on the current register values
		in_dial    = s.mode_cfg[MODE_MSB:MODE_LSB] == MODE_DIAL;
		pulse_mode = !s.tone_stat[TONE_DIAL_BIT];
		timed      = pulse_mode | s.tone_stat[TIMED_DIAL_BIT];
		rts        = s.host_ctl[RTS_BIT];
		rts_rise   = rts & !s.rts_prev;
		npulse     = pulse_count(s.tone_stat[DIGIT_MSB:DIGIT_LSB]);
		next_s.rts_prev = rts;

		if (tick && s.dial_st != DIAL_IDLE) begin
			if (s.timer <= 16'h0001) begin
				expire = 1'b1;
			end else begin
				next_s.timer = s.timer - 16'h0001;
			end
		end

		case (s.dial_st)
			DIAL_IDLE: begin
				if (in_dial && timed && rts_rise) begin
					next_s.busy = 1'b1;
					if (!pulse_mode) begin
						next_s.dial_st = DIAL_TONE_ON;
						next_s.timer   = s.make_cnt;
					end else if (npulse == 4'h0) begin
						next_s.dial_st = DIAL_PAUSE;
						next_s.timer   = s.pause_cnt;
					end else begin
						next_s.dial_st = DIAL_BREAK;
						next_s.timer   = s.break_cnt;
						next_s.pulses  = npulse - 4'h1;
					end
				end
			end
			DIAL_TONE_ON: begin
				if (expire) begin
					next_s.dial_st = DIAL_TONE_GAP;
					next_s.timer   = s.break_cnt;
				end
			end
			DIAL_TONE_GAP: begin
				if (expire) begin
					next_s.dial_st = DIAL_IDLE;
					next_s.busy    = 1'b0;
				end
			end
			DIAL_BREAK: begin
				if (expire) begin
					next_s.dial_st = DIAL_MAKE;
					next_s.timer   = s.make_cnt;
				end
			end
			DIAL_MAKE: begin
				if (expire && s.pulses == 4'h0) begin
					next_s.dial_st = DIAL_PAUSE;
					next_s.timer   = s.pause_cnt;
				end else if (expire) begin
					next_s.dial_st = DIAL_BREAK;
					next_s.timer   = s.break_cnt;
					next_s.pulses  = s.pulses - 4'h1;
				end
			end
			DIAL_PAUSE: begin
				if (expire) begin
					next_s.dial_st = DIAL_IDLE;
					next_s.busy    = 1'b0;
				end
			end
			default: begin
				next_s.dial_st = DIAL_IDLE;
				next_s.busy    = 1'b0;
			end
		endcase

		// leaving dial mode abandons a digit in progress
		if (!in_dial) begin
			next_s.dial_st = DIAL_IDLE;
			next_s.busy    = 1'b0;
		end

		// hook: pulse cadence overrides the host hook request
		if (next_s.dial_st == DIAL_BREAK) begin
			next_s.off_hook = 1'b0;
		end else if (next_s.dial_st == DIAL_MAKE ||
			next_s.dial_st == DIAL_PAUSE) begin
			next_s.off_hook = 1'b1;
		end else begin
			next_s.off_hook = s.host_ctl[HOOK_REQ_BIT];
		end
		next_s.seize_b = !next_s.off_hook;

		// tone on for a timed digit, or while request to send is high in untimed tone dialing
		next_s.dtmf_on = (next_s.dial_st == DIAL_TONE_ON) ||
			(in_dial && !pulse_mode && !timed && rts);

		// handshake and connection status
		connect = is_connect_mode(s.mode_cfg);
		manual  = s.mode_cfg[MANUAL_HS_BIT];
		next_s.auto_hs = connect && !manual;
		next_s.tx_sel  = manual ?
			s.train_ctl[TX_SEL_MSB:TX_SEL_LSB] : SIG_SILENCE;
		next_s.carrier = connect && pins[SYNC_LINK] &&
			!pins[SYNC_LOSS] && !pins[SYNC_RETRAIN] &&
			!pins[SYNC_HANGUP];
		next_s.retrain = pins[SYNC_RETRAIN];
		// mark until the receiver is ready for remote data
		next_s.rx_out = (connect && pins[SYNC_LINK]) ?
			pins[SYNC_RXD] : 1'b1;
	end

	//==========================================================================
	// registers
	always_ff @(posedge CORE_CLK) begin
		if (!RST_B) begin
			s           <= '0;
			s.tone_stat <= TONE_STATUS_RESET;
			s.waitreq   <= 1'b1;
			s.seize_b   <= 1'b1;
			s.rx_out    <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	//==========================================================================
	// outputs straight from state
	assign AVS_READDATA     = s.readdata;
	assign AVS_WAITREQUEST  = s.waitreq;
	assign RX_DATA_OUT      = s.rx_out;
	assign LINE_SEIZE_PIN_B = s.seize_b;
	assign DTMF_ENABLE      = s.dtmf_on;
	assign DTMF_DIGIT       = s.tone_stat[DIGIT_MSB:DIGIT_LSB];
	assign HIGH_TONE_LEVEL  = s.hi_lev;
	assign LOW_TONE_LEVEL   = s.lo_lev;
	assign TX_SIGNAL_SEL    = s.tx_sel;
	assign AUTO_HANDSHAKE   = s.auto_hs;
	assign FORCE_16WAY      = s.train_ctl[FORCE16_BIT];

endmodule
`default_nettype wire

// ### shared/dial_seq_pkg.sv
// package: register map, field layout and timing for the dial sequencer
//==============================================================================
// Summary of operation
// - busy flag high from dial start to finish
// - pulse cadence on hook pin, mirrored in status
// - pulse dialing ignores timed select, always timed
// - manual handshake stops own handshake signals
// - three-bit field selects the transmitted signal
// - detector bits follow remote handshake signals
// - force bit makes receiver use 16-way decisions
// - received data held at mark until ready
// - carrier flag set once connection is ready
// - carrier flag cleared on dropout, retrain, hangup
package dial_seq_pkg;

	//==========================================================================
	// register byte offsets
	localparam logic [5:0] OFS_MODE_CONFIG   = 6'h00;
	localparam logic [5:0] OFS_TONE_STATUS   = 6'h04;
	localparam logic [5:0] OFS_HOST_CONTROL  = 6'h08;
	localparam logic [5:0] OFS_HOST_STATUS   = 6'h0c;
	localparam logic [5:0] OFS_MODEM_STATUS  = 6'h10;
	localparam logic [5:0] OFS_TRAINING_CTL  = 6'h14;
	localparam logic [5:0] OFS_MAKE_COUNT    = 6'h18;
	localparam logic [5:0] OFS_BREAK_COUNT   = 6'h1c;
	localparam logic [5:0] OFS_PAUSE_COUNT   = 6'h20;
	localparam logic [5:0] OFS_HIGH_LEVEL    = 6'h24;
	localparam logic [5:0] OFS_LOW_LEVEL     = 6'h28;

	//==========================================================================
	// field positions
	localparam int MODE_LSB         = 0;
	localparam int MODE_MSB         = 6;
	localparam int MANUAL_HS_BIT    = 10;
	localparam int DIGIT_LSB        = 0;
	localparam int DIGIT_MSB        = 3;
	localparam int TIMED_DIAL_BIT   = 4;
	localparam int TONE_DIAL_BIT    = 7;
	localparam int HOOK_REQ_BIT     = 0;
	localparam int RTS_BIT          = 3;
	localparam int CARRIER_BIT      = 1;
	localparam int RETRAIN_BIT      = 2;
	localparam int BUSY_BIT         = 4;
	localparam int LINE_SEIZED_BIT  = 2;
	localparam int TX_SEL_LSB       = 0;
	localparam int TX_SEL_MSB       = 2;
	localparam int FORCE16_BIT      = 3;
	localparam int USB1_SEEN_BIT    = 5;
	localparam int S1_SEEN_BIT      = 6;
	localparam int SB1_SEEN_BIT     = 7;

	//==========================================================================
	// reset values, writable masks and codes
	localparam logic [15:0] TONE_STATUS_RESET = 16'h0080;
	localparam logic [7:0]  HOST_CTL_MASK     = 8'h09;
	localparam logic [7:0]  TRAIN_CTL_MASK    = 8'h0f;
	localparam logic [6:0]  MODE_STANDBY      = 7'h00;
	localparam logic [6:0]  MODE_DIAL         = 7'h03;
	localparam logic [6:0]  MODE_CONNECT      = 7'h08;
	localparam logic [6:0]  MODE_CONNECT_MAN  = 7'h09;
	localparam logic [2:0]  SIG_SILENCE       = 3'h0;
	localparam logic [3:0]  PULSE_ZERO_DIGIT  = 4'h0;
	localparam logic [3:0]  PULSE_MAX_DIGIT   = 4'h9;
	localparam logic [3:0]  PULSES_FOR_ZERO   = 4'ha;

	//==========================================================================
	// synchronised pin bits
	localparam int SYNC_WIDTH    = 8;
	localparam int SYNC_USB1     = 0;
	localparam int SYNC_S1       = 1;
	localparam int SYNC_SB1      = 2;
	localparam int SYNC_LINK     = 3;
	localparam int SYNC_LOSS     = 4;
	localparam int SYNC_RETRAIN  = 5;
	localparam int SYNC_HANGUP   = 6;
	localparam int SYNC_RXD      = 7;

	//==========================================================================
	// timing: dial counts are in sample periods
	localparam int CLK_HZ         = 50_000_000;
	localparam int SAMPLE_HZ      = 9600;
	localparam int TICK_DIV_CYCLES = CLK_HZ / SAMPLE_HZ;

	typedef enum logic [2:0] {
		DIAL_IDLE     = 3'h0,
		DIAL_TONE_ON  = 3'h1,
		DIAL_TONE_GAP = 3'h3,
		DIAL_BREAK    = 3'h2,
		DIAL_MAKE     = 3'h6,
		DIAL_PAUSE    = 3'h7
	} dial_state_type;

endpackage

// ### rtl/pin_synchronizer.sv
// module: two flip-flop synchroniser for a group of pin levels
`timescale 1ns/1ps
`default_nettype none
module pin_synchronizer #(
	parameter int WIDTH = 8
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [1:0][WIDTH-1:0] stage;
	logic [1:0][WIDTH-1:0] next_stage;

	//==========================================================================
	// first stage feeds only the second
	always_comb begin
		next_stage[0] = async_in;
		next_stage[1] = stage[0];
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			stage <= '0;
		end else begin
			stage <= next_stage;
		end
	end

	assign sync_out = stage[1];
endmodule
`default_nettype wire

// ### rtl/sample_tick.sv
// module: divider giving a one-cycle enable at the sample rate
`timescale 1ns/1ps
`default_nettype none
module sample_tick #(
	parameter int unsigned DIV = 5208
) (
	input  wire logic clk,
	input  wire logic rst_b,
	output logic      tick
);
	typedef struct packed {
		logic [15:0] count;
		logic        tick;
	} div_state_type;

	div_state_type s;
	div_state_type next_s;

	//==========================================================================
	// free running; dial timing may start mid period, a sample of slack
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (s.count >= 16'(DIV - 1)) begin
			next_s.count = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.count = s.count + 16'h0001;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick = s.tick;
endmodule
`default_nettype wire

// ### tb/dial_and_handshake_sequencer_assertions.sv
// checker: port-level properties of the dial and handshake sequencer
`timescale 1ns/1ps
`default_nettype none
module dial_seq_checker
	import dial_seq_pkg::*;
(
	input wire logic        CORE_CLK,
	input wire logic        RST_B,
	input wire logic [5:0]  AVS_ADDRESS,
	input wire logic        AVS_READ,
	input wire logic        AVS_WRITE,
	input wire logic [31:0] AVS_WRITEDATA,
	input wire logic [3:0]  AVS_BYTEENABLE,
	input wire logic [31:0] AVS_READDATA,
	input wire logic        AVS_WAITREQUEST,
	input wire logic        LINK_READY_IN,
	input wire logic        CARRIER_LOSS_IN,
	input wire logic        RETRAIN_IN,
	input wire logic        HANGUP_IN,
	input wire logic        RX_DATA_OUT,
	input wire logic        LINE_SEIZE_PIN_B,
	input wire logic        DTMF_ENABLE,
	input wire logic [2:0]  TX_SIGNAL_SEL,
	input wire logic        AUTO_HANDSHAKE,
	input wire logic        FORCE_16WAY
);
	//==========================================================================
	// helpers
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_B);
	logic rd_ok;
	logic drop;
	assign rd_ok = AVS_READ && !AVS_WAITREQUEST;
	assign drop  = CARRIER_LOSS_IN || RETRAIN_IN || HANGUP_IN;

	//==========================================================================
	// properties
	chk_bus_answer: assert property (
		(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
		else $error("request not answered next cycle");
	chk_answer_once: assert property (
		!AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("waitrequest low longer than one cycle");
	chk_no_stray: assert property (
		!(AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> AVS_WAITREQUEST)
		else $error("answer without request");
	// five samples cover the synchroniser plus the output flop
	chk_rx_mark: assert property (
		!LINK_READY_IN [*5] |-> RX_DATA_OUT)
		else $error("receive data left mark before link ready");
	chk_auto_silent: assert property (
		AUTO_HANDSHAKE |-> TX_SIGNAL_SEL == SIG_SILENCE)
		else $error("host signal select leaks in automatic mode");
	chk_carrier_drop: assert property (
		drop [*6] ##0 (rd_ok && AVS_ADDRESS == OFS_HOST_STATUS)
		|-> !AVS_READDATA[CARRIER_BIT])
		else $error("carrier flag set during dropout");
	chk_retrain_flag: assert property (
		RETRAIN_IN [*6] ##0 (rd_ok && AVS_ADDRESS == OFS_HOST_STATUS)
		|-> AVS_READDATA[RETRAIN_BIT])
		else $error("retrain flag missing");
	chk_seize_mirror: assert property (
		rd_ok && AVS_ADDRESS == OFS_MODEM_STATUS && $stable(LINE_SEIZE_PIN_B)
		|-> AVS_READDATA[LINE_SEIZED_BIT] == !LINE_SEIZE_PIN_B)
		else $error("line seized flag differs from hook pin");
	chk_force_follow: assert property (
		AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == OFS_TRAINING_CTL
		&& AVS_BYTEENABLE[0]
		|=> ##1 FORCE_16WAY == $past(AVS_WRITEDATA[FORCE16_BIT], 2))
		else $error("force decision output not updated");
	cover property (DTMF_ENABLE);
	cover property ($rose(LINE_SEIZE_PIN_B));
	cover property (AUTO_HANDSHAKE && LINK_READY_IN);
endmodule
bind dial_and_handshake_sequencer dial_seq_checker u_dial_seq_checker (
	.CORE_CLK, .RST_B, .AVS_ADDRESS, .AVS_READ, .AVS_WRITE, .AVS_WRITEDATA,
	.AVS_BYTEENABLE, .AVS_READDATA, .AVS_WAITREQUEST, .LINK_READY_IN,
	.CARRIER_LOSS_IN, .RETRAIN_IN, .HANGUP_IN, .RX_DATA_OUT,
	.LINE_SEIZE_PIN_B, .DTMF_ENABLE, .TX_SIGNAL_SEL, .AUTO_HANDSHAKE,
	.FORCE_16WAY
);
`default_nettype wire

// ### tb/remote_line_model.sv
// partner: remote modem and line levels seen by the sequencer pins
`timescale 1ns/1ps
`default_nettype none
module remote_line_model (
	input  wire logic       clk,
	input  wire logic [7:0] want,
	output logic      [7:0] line
);
	// idle line: nothing detected, receive data at mark
	initial line = 8'h80;
	// levels move one edge after the request, like a real far end
	always @(posedge clk) begin
		line <= want;
	end
endmodule
`default_nettype wire

// ### tb/dial_and_handshake_sequencer_tb_top.sv
// bench: register-level scenarios for the dial and handshake sequencer
`timescale 1ns/1ps
`default_nettype none
module dial_and_handshake_sequencer_tb_top;
	import dial_seq_pkg::*;
	localparam int LIMIT = 20000;
	logic        clk = 1'b0;
	logic        rst_b = 1'b0;
	logic [5:0]  adr = 6'h00;
	logic        rd = 1'b0;
	logic        wr = 1'b0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic        waitreq;
	logic [7:0]  want = 8'h80;
	logic [7:0]  line;
	logic        rx_out;
	logic        seize_b;
	logic        seize_q = 1'b0;
	logic        dtmf_en;
	logic [3:0]  digit;
	logic [15:0] hi_lev;
	logic [15:0] lo_lev;
	logic [2:0]  tx_sel;
	logic        auto_hs;
	logic        force16;
	int          miscompares = 0;
	int          checks = 0;
	int          cycles = 0;
	int          rises = 0;
	int          tone_cyc = 0;
	logic [31:0] t_digits [2] = '{32'h5, 32'hb};

	dial_and_handshake_sequencer #(
		.TICK_DIV(4)
	) u_dial_and_handshake_sequencer (
		.CORE_CLK(clk), .RST_B(rst_b), .AVS_ADDRESS(adr), .AVS_READ(rd),
		.AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(4'hf),
		.AVS_READDATA(rdat), .AVS_WAITREQUEST(waitreq),
		.REMOTE_USB1_IN(line[SYNC_USB1]), .REMOTE_S1_IN(line[SYNC_S1]),
		.REMOTE_SB1_IN(line[SYNC_SB1]), .LINK_READY_IN(line[SYNC_LINK]),
		.CARRIER_LOSS_IN(line[SYNC_LOSS]), .RETRAIN_IN(line[SYNC_RETRAIN]),
		.HANGUP_IN(line[SYNC_HANGUP]), .RX_DATA_IN(line[SYNC_RXD]),
		.RX_DATA_OUT(rx_out), .LINE_SEIZE_PIN_B(seize_b), .DTMF_ENABLE(dtmf_en),
		.DTMF_DIGIT(digit), .HIGH_TONE_LEVEL(hi_lev), .LOW_TONE_LEVEL(lo_lev),
		.TX_SIGNAL_SEL(tx_sel), .AUTO_HANDSHAKE(auto_hs), .FORCE_16WAY(force16));
	remote_line_model u_remote_line_model (.clk(clk), .want(want), .line(line));

	//==========================================================================
	// clock, monitors, timeout
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		seize_q <= seize_b;
		if (seize_b === 1'b1 && seize_q === 1'b0) rises++;
		if (dtmf_en === 1'b1) tone_cyc++;
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			stop_test();
		end
	end

	//==========================================================================
	// shared tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// holds the request until waitrequest is sampled low
	task automatic bus(input logic w, input logic [5:0] a,
			input logic [31:0] d, output logic [31:0] q);
		int n = 0;
		@(posedge clk);
		adr <= a;
		wdat <= d;
		rd <= !w;
		wr <= w;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 50);
		q = rdat;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 50) check(32'h0, 32'h1);
	endtask
	task automatic wr32(input logic [5:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [31:0] m, e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		check(q & m, e);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task automatic set_line(input logic [7:0] v);
		@(posedge clk);
		want <= v;
		idle(8);
	endtask
	task automatic wait_busy();
		logic [31:0] q = 32'h10;
		for (int i = 0; i < 100 && q[BUSY_BIT] !== 1'b0; i++) begin
			bus(1'b0, OFS_HOST_STATUS, 32'h0, q);
		end
		check(q & 32'h10, 32'h0);
	endtask

	//==========================================================================
	// scenarios
	task automatic t_reset();
		rd_chk(OFS_TONE_STATUS, 32'hffff, {16'h0, TONE_STATUS_RESET});
		rd_chk(6'h2c, 32'hffffffff, 32'h0);
		check(32'({seize_b, rx_out}), 32'h3);
		$display("reset test done");
	endtask
	task automatic t_tone();
		int t0;
		wr32(OFS_HOST_CONTROL, 32'h1);
		wr32(OFS_MODE_CONFIG, 32'(MODE_DIAL));
		wr32(OFS_MAKE_COUNT, 32'h2);
		wr32(OFS_BREAK_COUNT, 32'h1);
		wr32(OFS_HIGH_LEVEL, 32'h3c00);
		wr32(OFS_LOW_LEVEL, 32'h3c00);
		// the level register loads on the completing edge itself
		idle(1);
		check({hi_lev, lo_lev}, 32'h3c003c00);
		foreach (t_digits[i]) begin
			t0 = tone_cyc;
			wr32(OFS_TONE_STATUS, 32'h90 | t_digits[i]);
			wr32(OFS_HOST_CONTROL, 32'h9);
			rd_chk(OFS_HOST_STATUS, 32'h10, 32'h10);
			check(32'(digit), t_digits[i]);
			wait_busy();
			check(32'((tone_cyc - t0) inside {[4:8]}), 32'h1);
			wr32(OFS_HOST_CONTROL, 32'h1);
		end
		wr32(OFS_MODE_CONFIG, 32'(MODE_STANDBY));
		$display("timed tone test done");
	endtask
	task automatic t_cont();
		wr32(OFS_MODE_CONFIG, 32'(MODE_DIAL));
		wr32(OFS_TONE_STATUS, 32'h87);
		wr32(OFS_HOST_CONTROL, 32'h9);
		idle(3);
		check(32'({dtmf_en, digit}), 32'h17);
		rd_chk(OFS_HOST_STATUS, 32'h10, 32'h0);
		wr32(OFS_HOST_CONTROL, 32'h1);
		idle(3);
		check(32'(dtmf_en), 32'h0);
		$display("continuous tone test done");
	endtask
	task automatic t_pulse();
		int r0;
		wr32(OFS_TONE_STATUS, 32'h3);
		wr32(OFS_MAKE_COUNT, 32'h1);
		wr32(OFS_BREAK_COUNT, 32'h1);
		wr32(OFS_PAUSE_COUNT, 32'h2);
		for (int d = 3; d >= 0; d -= 3) begin
			r0 = rises;
			wr32(OFS_TONE_STATUS, 32'(d));
			wr32(OFS_HOST_CONTROL, 32'h9);
			rd_chk(OFS_HOST_STATUS, 32'h10, 32'h10);
			wait_busy();
			check(32'(rises - r0), (d == 0) ? 32'ha : 32'(d));
			rd_chk(OFS_MODEM_STATUS, 32'h4, 32'h4);
			wr32(OFS_HOST_CONTROL, 32'h1);
		end
		wr32(OFS_MODE_CONFIG, 32'(MODE_STANDBY));
		$display("pulse test done");
	endtask
	task automatic t_manual();
		wr32(OFS_MODE_CONFIG, 32'h4409);
		for (int k = 0; k < 8; k++) begin
			wr32(OFS_TRAINING_CTL, 32'(k));
			idle(2);
			check(32'({auto_hs, tx_sel}), 32'(k));
		end
		wr32(OFS_TRAINING_CTL, 32'h8);
		idle(2);
		check(32'(force16), 32'h1);
		for (int i = 0; i < 3; i++) begin
			set_line(8'h80 | (8'h1 << i));
			rd_chk(OFS_TRAINING_CTL, 32'he0, 32'h20 << i);
		end
		set_line(8'h80);
		rd_chk(OFS_TRAINING_CTL, 32'he0, 32'h0);
		// originator: remote scrambled ones lead to the 1200 path
		wr32(OFS_TRAINING_CTL, 32'h3);
		set_line(8'h84);
		rd_chk(OFS_TRAINING_CTL, 32'he0, 32'h80);
		wr32(OFS_TRAINING_CTL, 32'h5);
		idle(2);
		check(32'({force16, tx_sel}), 32'h5);
		// answerer: standby silence, answer mode with manual kept
		set_line(8'h80);
		wr32(OFS_MODE_CONFIG, 32'(MODE_STANDBY));
		idle(2);
		check(32'({auto_hs, tx_sel}), 32'h0);
		wr32(OFS_MODE_CONFIG, 32'h408);
		wr32(OFS_TRAINING_CTL, 32'h1);
		idle(2);
		check(32'({auto_hs, tx_sel, rx_out}), 32'h3);
		set_line(8'h82);
		rd_chk(OFS_TRAINING_CTL, 32'he0, 32'h40);
		set_line(8'h80);
		wr32(OFS_TRAINING_CTL, 32'h2);
		wr32(OFS_TRAINING_CTL, 32'h3);
		wr32(OFS_TRAINING_CTL, 32'hc);
		idle(2);
		check(32'({force16, tx_sel}), 32'hc);
		wr32(OFS_TRAINING_CTL, 32'he);
		idle(2);
		check(32'(tx_sel), 32'h6);
		// answerer: scrambled ones instead of S1 give the 1200 path
		wr32(OFS_TRAINING_CTL, 32'h1);
		set_line(8'h84);
		rd_chk(OFS_TRAINING_CTL, 32'he0, 32'h80);
		wr32(OFS_TRAINING_CTL, 32'h3);
		idle(2);
		check(32'(tx_sel), 32'h3);
		wr32(OFS_TRAINING_CTL, 32'h5);
		idle(2);
		check(32'({auto_hs, tx_sel}), 32'h5);
		$display("manual handshake test done");
	endtask
	task automatic t_auto();
		wr32(OFS_MODE_CONFIG, 32'h4008);
		set_line(8'h00);
		check(32'({auto_hs, tx_sel, rx_out}), 32'h11);
		rd_chk(OFS_HOST_STATUS, 32'h2, 32'h0);
		set_line(8'h08);
		check(32'(rx_out), 32'h0);
		rd_chk(OFS_HOST_STATUS, 32'h2, 32'h2);
		for (int i = SYNC_LOSS; i <= SYNC_HANGUP; i++) begin
			set_line(8'h08 | (8'h1 << i));
			rd_chk(OFS_HOST_STATUS, 32'h6, 32'(i == SYNC_RETRAIN) << 2);
		end
		set_line(8'h08);
		rd_chk(OFS_HOST_STATUS, 32'h6, 32'h2);
		$display("automatic connect test done");
	endtask

	//==========================================================================
	// run and verdict
	task automatic stop_test();
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		idle(20);
		rst_b <= 1'b1;
		t_reset();
		t_tone();
		t_cont();
		t_pulse();
		t_manual();
		t_auto();
		stop_test();
	end
endmodule
`default_nettype wire
